// ---- shared/srpl_pkg.sv ----
// Constants and types for the serial ROM register preloader.
// Assumes a 100 MHz CLOCK and a two-wire ROM that answers device address A0h.
package srpl_pkg;
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int SCL_PERIOD_NS = 2500;
	localparam int QTR_CYCLES = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
	localparam logic [7:0] QTR_LAST = 8'(QTR_CYCLES - 1);
	// Serial ROM protocol
	localparam logic [7:0] DEV_WRITE_ADDR = 8'hA0;
	localparam logic [7:0] DEV_READ_ADDR = 8'hA1;
	localparam logic [7:0] END_OF_LIST = 8'hFF;
	localparam logic [7:0] FIRST_WORD_ADDR = 8'h00;
	localparam logic [7:0] RECORD_STEP = 8'h08;
	localparam logic [7:0] LAST_RECORD_ADDR = 8'hF8;
	localparam logic [1:0] DATA_BYTES_LAST = 2'h3;
	localparam logic [3:0] ACK_BIT = 4'h8;
	// Register map (byte addresses)
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_CONTROL = 8'h04;
	localparam logic [7:0] REG_IMAGE_BASE = 8'h08;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_ERR_BIT = 1;
	localparam int STAT_PRESENT_BIT = 2;
	localparam int CTRL_RELOAD_BIT = 0;
	// Register images: 0 subsystem 40h, 1 system control 80h, 2 GP 88h,
	// 3 pin routing 8Ch, 4 card/device/diag 90h, 5 power mgmt A0h, 6 legacy
	localparam int IMG_COUNT = 7;
	localparam logic [31:0] IMG_RESET = 32'h0000_0000;
	typedef enum logic [3:0] {
		ST_IDLE, ST_DETECT, ST_START, ST_DEVW, ST_WADDR, ST_RSTART,
		ST_DEVR, ST_REF, ST_DATA, ST_STOP, ST_DONE
	} srpl_state_type;
endpackage

// ---- verilog/srpl_preloader.sv ----
// Serial ROM register preloader: two-wire master, record parser, images.
// Assumes open-drain pins with external pullups and a classic Wishbone master.
`timescale 1ns/1ns
`default_nettype none
module srpl_preloader import srpl_pkg::*; (
	// Clock, reset, enable
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic CE,
	// Wishbone slave
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	// Two-wire ROM pins
	output logic SCL_O,
	output logic SCL_OE,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE,
	// Status
	output logic ROM_PRESENT_FLAG,
	output logic LOAD_ERROR_FLAG,
	output logic LOAD_BUSY_FLAG
);
	// Reference decode: {defined, loads, image index, lane, bit mask}
	function automatic logic [14:0] ref_map(input logic [7:0] r);
		case (r)
			8'h21: ref_map = {2'b11, 3'h0, 2'h3, 8'hFF};
			8'h22: ref_map = {2'b11, 3'h0, 2'h2, 8'hFF};
			8'h23: ref_map = {2'b11, 3'h0, 2'h1, 8'hFF};
			8'h24: ref_map = {2'b11, 3'h0, 2'h0, 8'hFF};
			8'h25: ref_map = {2'b11, 3'h1, 2'h0, 8'h7B};
			8'h26: ref_map = {2'b11, 3'h1, 2'h1, 8'hC0};
			8'h27: ref_map = {2'b11, 3'h1, 2'h2, 8'h7F};
			8'h28: ref_map = {2'b11, 3'h1, 2'h3, 8'hED};
			8'h29: ref_map = {2'b10, 3'h0, 2'h0, 8'h00};
			8'h2A: ref_map = {2'b11, 3'h2, 2'h1, 8'hCF};
			8'h2B: ref_map = {2'b11, 3'h2, 2'h3, 8'h0F};
			8'h2C: ref_map = {2'b11, 3'h3, 2'h0, 8'hFF};
			8'h2D: ref_map = {2'b11, 3'h3, 2'h1, 8'hFF};
			8'h2E: ref_map = {2'b11, 3'h3, 2'h2, 8'hFF};
			8'h2F: ref_map = {2'b11, 3'h3, 2'h3, 8'hFF};
			8'h30: ref_map = {2'b11, 3'h4, 2'h1, 8'h86};
			8'h31: ref_map = {2'b11, 3'h4, 2'h2, 8'hFF};
			8'h32: ref_map = {2'b11, 3'h4, 2'h3, 8'h9F};
			8'h33: ref_map = {2'b11, 3'h5, 2'h3, 8'h80};
			8'h34: ref_map = {2'b11, 3'h6, 2'h0, 8'hFF};
			default: ref_map = 15'h0000;
		endcase
	endfunction

	srpl_state_type state_q;
	logic [7:0] qcnt_q;
	logic [1:0] phase_q;
	logic [3:0] bitn_q;
	logic [7:0] shift_q;
	logic [7:0] addr_q;
	logic [7:0] ref_q;
	logic [31:0] data_q;
	logic [1:0] bcnt_q;
	logic nack_q;
	logic more_q;
	logic sda_meta_q;
	logic sda_sync_q;
	logic present_q;
	logic error_q;
	logic commit_q;
	logic [31:0] img_q [IMG_COUNT];
	logic ack_q;
	logic [31:0] rdat_q;
	logic scl_oe_q;
	logic sda_oe_q;

	logic tick;
	logic act;
	logic op_end;
	logic is_write;
	logic is_read;
	logic is_single;
	logic [7:0] tx_byte;
	logic rx_ack;
	logic [14:0] cur_map;
	logic wb_req;
	logic wb_wr;
	logic reload;
	logic [7:0] wb_word;

	assign tick = (qcnt_q == QTR_LAST);
	assign act = (qcnt_q == 8'h00);
	assign is_write = (state_q == ST_DEVW) || (state_q == ST_WADDR) ||
		(state_q == ST_DEVR);
	assign is_read = (state_q == ST_REF) || (state_q == ST_DATA);
	assign is_single = (state_q == ST_START) || (state_q == ST_RSTART) ||
		(state_q == ST_STOP);
	assign op_end = tick && (phase_q == 2'h3) &&
		(is_single || (bitn_q == ACK_BIT));
	assign cur_map = ref_map((state_q == ST_REF) ? shift_q : ref_q);
	assign wb_req = WB_CYC_I && WB_STB_I;
	assign wb_wr = wb_req && WB_WE_I && ack_q;
	assign wb_word = {WB_ADR_I[7:2], 2'b00};
	assign reload = wb_wr && (wb_word == REG_CONTROL) && WB_SEL_I[0] &&
		WB_DAT_I[CTRL_RELOAD_BIT];

	assign tx_byte = (state_q == ST_DEVW) ? DEV_WRITE_ADDR :
		(state_q == ST_DEVR) ? DEV_READ_ADDR : addr_q;
	// Acknowledge a reference only if more bytes are wanted from this record
	assign rx_ack = (state_q == ST_REF) ? (cur_map[14] &&
		shift_q != END_OF_LIST) : (bcnt_q != DATA_BYTES_LAST);

	// Data line synchroniser
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			sda_meta_q <= 1'b1;
			sda_sync_q <= 1'b1;
		end else if (CE) begin
			sda_meta_q <= SDA_I;
			sda_sync_q <= sda_meta_q;
		end
	end

	// Quarter-bit timing
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			qcnt_q <= 8'h00;
			phase_q <= 2'h0;
			bitn_q <= 4'h0;
		end else if (CE) begin
			if (state_q == ST_IDLE || state_q == ST_DONE) begin
				qcnt_q <= 8'h00;
				phase_q <= 2'h0;
				bitn_q <= 4'h0;
			end else if (tick) begin
				qcnt_q <= 8'h00;
				phase_q <= phase_q + 2'h1;
				if (op_end || state_q == ST_DETECT) begin
					phase_q <= 2'h0;
					bitn_q <= 4'h0;
				end else if (phase_q == 2'h3) begin
					bitn_q <= bitn_q + 4'h1;
				end
			end else begin
				qcnt_q <= qcnt_q + 8'h01;
			end
		end
	end

	// Pin drive: in byte states clock low in phases 0 and 3, data set while clock is low
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end else if (CE && act) begin
			case (state_q)
				ST_START, ST_RSTART: begin
					case (phase_q)
						2'h0: sda_oe_q <= 1'b0;
						2'h1: scl_oe_q <= 1'b0;
						2'h2: sda_oe_q <= 1'b1;
						default: scl_oe_q <= 1'b1;
					endcase
				end
				ST_STOP: begin
					case (phase_q)
						2'h0: sda_oe_q <= 1'b1;
						2'h1: scl_oe_q <= 1'b0;
						2'h2: sda_oe_q <= 1'b0;
						default: scl_oe_q <= 1'b0;
					endcase
				end
				ST_DEVW, ST_WADDR, ST_DEVR, ST_REF, ST_DATA: begin
					case (phase_q)
						2'h0: begin
							scl_oe_q <= 1'b1;
							if (bitn_q == ACK_BIT) begin
								sda_oe_q <= is_read && rx_ack;
							end else begin
								sda_oe_q <= is_write && !tx_byte[3'(7 - bitn_q)];
							end
						end
						2'h1: scl_oe_q <= 1'b0;
						2'h2: scl_oe_q <= 1'b0;
						default: scl_oe_q <= 1'b1;
					endcase
				end
				default: begin
					scl_oe_q <= 1'b0;
					sda_oe_q <= 1'b0;
				end
			endcase
		end
	end

	// Receive shifter and missing acknowledge capture
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			shift_q <= 8'h00;
			nack_q <= 1'b0;
		end else if (CE) begin
			if (op_end) begin
				nack_q <= 1'b0;
			end else if (act && phase_q == 2'h2) begin
				if (is_read && bitn_q != ACK_BIT) begin
					shift_q <= {shift_q[6:0], sda_sync_q};
				end
				if (is_write && bitn_q == ACK_BIT && sda_sync_q) begin
					nack_q <= 1'b1;
				end
			end
		end
	end

	// Sequencer
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			state_q <= ST_DETECT;
			addr_q <= FIRST_WORD_ADDR;
			ref_q <= 8'h00;
			data_q <= 32'h0000_0000;
			bcnt_q <= 2'h0;
			more_q <= 1'b0;
			present_q <= 1'b0;
			error_q <= 1'b0;
			commit_q <= 1'b0;
		end else if (CE) begin
			commit_q <= 1'b0;
			case (state_q)
				ST_IDLE, ST_DONE: begin
					if (reload) begin
						state_q <= ST_DETECT;
					end
				end
				ST_DETECT: begin
					if (tick) begin
						present_q <= sda_sync_q;
						error_q <= 1'b0;
						addr_q <= FIRST_WORD_ADDR;
						more_q <= 1'b0;
						state_q <= sda_sync_q ? ST_START : ST_DONE;
					end
				end
				ST_START: if (op_end) state_q <= ST_DEVW;
				ST_DEVW, ST_WADDR, ST_DEVR: begin
					if (op_end) begin
						if (nack_q) begin
							error_q <= 1'b1;
							more_q <= 1'b0;
							state_q <= ST_STOP;
						end else if (state_q == ST_DEVW) begin
							state_q <= ST_WADDR;
						end else if (state_q == ST_WADDR) begin
							state_q <= ST_RSTART;
						end else begin
							state_q <= ST_REF;
						end
					end
				end
				ST_RSTART: if (op_end) state_q <= ST_DEVR;
				ST_REF: begin
					if (op_end) begin
						ref_q <= shift_q;
						bcnt_q <= 2'h0;
						more_q <= 1'b0;
						if (shift_q == END_OF_LIST) begin
							state_q <= ST_STOP;
						end else if (!cur_map[14]) begin
							error_q <= 1'b1;
							state_q <= ST_STOP;
						end else begin
							state_q <= ST_DATA;
						end
					end
				end
				ST_DATA: begin
					if (op_end) begin
						data_q <= {data_q[23:0], shift_q};
						bcnt_q <= bcnt_q + 2'h1;
						if (bcnt_q == DATA_BYTES_LAST) begin
							commit_q <= 1'b1;
							state_q <= ST_STOP;
							if (addr_q == LAST_RECORD_ADDR) begin
								error_q <= 1'b1;
							end else begin
								addr_q <= addr_q + RECORD_STEP;
								more_q <= 1'b1;
							end
						end
					end
				end
				ST_STOP: begin
					if (op_end) begin
						state_q <= more_q ? ST_START : ST_DONE;
					end
				end
				default: state_q <= ST_DONE;
			endcase
		end
	end

	// Register images; a record commit outranks a bus write in the same cycle
	for (genvar gi = 0; gi < IMG_COUNT; gi++) begin : g_img
		always_ff @(posedge CLOCK) begin
			if (RST) begin
				img_q[gi] <= IMG_RESET;
			end else if (CE) begin
				if (commit_q && cur_map[13] &&
					cur_map[12:10] == 3'(gi)) begin
					img_q[gi][cur_map[9:8]*8 +: 8] <=
						(img_q[gi][cur_map[9:8]*8 +: 8] & ~cur_map[7:0]) |
						(data_q[cur_map[9:8]*8 +: 8] & cur_map[7:0]);
				end else if (wb_wr &&
					wb_word == REG_IMAGE_BASE + 8'(4 * gi)) begin
					for (int b = 0; b < 4; b++) begin
						if (WB_SEL_I[b]) begin
							img_q[gi][b*8 +: 8] <= WB_DAT_I[b*8 +: 8];
						end
					end
				end
			end
		end
	end

	// Wishbone: answer one cycle after the request, unmapped reads give zero
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			ack_q <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else if (CE) begin
			ack_q <= wb_req && !ack_q;
			if (wb_req && !ack_q) begin
				rdat_q <= 32'h0000_0000;
				if (wb_word == REG_STATUS) begin
					rdat_q[STAT_PRESENT_BIT] <= present_q;
					rdat_q[STAT_ERR_BIT] <= error_q;
					rdat_q[STAT_BUSY_BIT] <= LOAD_BUSY_FLAG;
				end else if (wb_word >= REG_IMAGE_BASE &&
					wb_word < REG_IMAGE_BASE + 8'(4 * IMG_COUNT)) begin
					rdat_q <= img_q[3'((wb_word - REG_IMAGE_BASE) >> 2)];
				end
			end
		end
	end

	// Status outputs
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			LOAD_BUSY_FLAG <= 1'b0;
		end else if (CE) begin
			LOAD_BUSY_FLAG <= (state_q != ST_IDLE) && (state_q != ST_DONE) &&
				(state_q != ST_DETECT);
		end
	end

	assign WB_ACK_O = ack_q;
	assign WB_DAT_O = rdat_q;
	assign SCL_OE = scl_oe_q;
	assign SDA_OE = sda_oe_q;
	assign SCL_O = 1'b0;
	assign SDA_O = 1'b0;
	assign ROM_PRESENT_FLAG = present_q;
	assign LOAD_ERROR_FLAG = error_q;
endmodule
`default_nettype wire

// ---- verification/srpl_monitor.sv ----
// Checker for the preloader's bus handshake and two-wire pin timing.
// Bound to srpl_preloader; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module srpl_monitor (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic CE,
	// Bus handshake
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_ACK_O,
	// Pins and flags
	input wire logic SCL_O,
	input wire logic SCL_OE,
	input wire logic SDA_O,
	input wire logic SDA_OE,
	input wire logic ROM_PRESENT_FLAG,
	input wire logic LOAD_ERROR_FLAG,
	input wire logic LOAD_BUSY_FLAG
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST);
	property p_ack;
		WB_CYC_I && WB_STB_I && !WB_ACK_O && CE |=> WB_ACK_O;
	endproperty
	a_ack: assert property (p_ack) else $error("no ack after request");
	property p_ack_pulse;
		WB_ACK_O |=> !WB_ACK_O;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_open_drain;
		SCL_O == 1'b0 && SDA_O == 1'b0;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("pin driven high");
	property p_scl_high;
		$fell(SCL_OE) |-> !SCL_OE [*8];
	endproperty
	a_scl_high: assert property (p_scl_high) else $error("clock high too short");
	property p_sda_steady;
		$fell(SCL_OE) |-> $stable(SDA_OE);
	endproperty
	a_sda_steady: assert property (p_sda_steady) else $error("data moved at clock rise");
	property p_scl_busy;
		$rose(SCL_OE) |-> LOAD_BUSY_FLAG;
	endproperty
	a_scl_busy: assert property (p_scl_busy) else $error("clock while not busy");
	property p_busy_present;
		LOAD_BUSY_FLAG |-> ROM_PRESENT_FLAG;
	endproperty
	a_busy_present: assert property (p_busy_present) else $error("busy without rom");
	property p_err_stop;
		$rose(LOAD_ERROR_FLAG) |-> ##[1:1000] !LOAD_BUSY_FLAG;
	endproperty
	a_err_stop: assert property (p_err_stop) else $error("load kept going");
endmodule
bind srpl_preloader srpl_monitor mon_u (.CLOCK, .RST, .CE, .WB_CYC_I,
	.WB_STB_I, .WB_ACK_O, .SCL_O, .SCL_OE, .SDA_O, .SDA_OE,
	.ROM_PRESENT_FLAG, .LOAD_ERROR_FLAG, .LOAD_BUSY_FLAG);
`default_nettype wire

// ---- verification/srpl_rom_model.sv ----
// Two-wire ROM model: byte store, auto-increment reads, address A0h.
// Assumes wires resolved by the bench; oe high pulls the data line low.
`timescale 1ns/1ns
`default_nettype none
module srpl_rom_model (
	// Clock and wires
	input wire logic clk,
	input wire logic scl,
	input wire logic sda,
	// Fault control: never acknowledge
	input wire logic mute,
	// Data pull-down
	output logic oe
);
	logic [7:0] mem [256];
	logic [7:0] sh = 8'h00, ptr = 8'h00, cur = 8'h00;
	logic [3:0] cnt = 4'h0;
	logic [1:0] ph = 2'h3;
	logic ps = 1'b1, pd = 1'b1;
	initial begin
		oe = 1'b0;
		for (int i = 0; i < 256; i++) mem[i] = 8'hFF;
	end
	always @(posedge clk) begin
		ps <= scl;
		pd <= sda;
		if (scl && ps && pd && !sda) begin
			cnt <= 4'h0;
			ph <= 2'h0;
			oe <= 1'b0;
		end else if (scl && ps && !pd && sda) begin
			ph <= 2'h3;
			oe <= 1'b0;
		end else if (scl && !ps) begin
			cnt <= (cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
			if (cnt != 4'h8) sh <= {sh[6:0], sda};
			else if (ph == 2'h2 && sda) ph <= 2'h3;
		end else if (!scl && ps) begin
			if (cnt == 4'h8)
				oe <= !mute && (ph == 2'h1 || (ph == 2'h0 && sh[7:1] == 7'h50));
			else if (cnt == 4'h9 && (ph == 2'h2 || (ph == 2'h0 && sh == 8'hA1 && !mute))) begin
				ph <= 2'h2;
				cur <= mem[ptr];
				ptr <= ptr + 8'h01;
				oe <= !mem[ptr][7];
			end else if (cnt == 4'h9) begin
				if (ph == 2'h1) ptr <= sh;
				ph <= (ph == 2'h0 && sh == 8'hA0) ? 2'h1 : 2'h3;
				oe <= 1'b0;
			end else if (ph == 2'h2 && cnt != 4'h0)
				oe <= !cur[3'(4'h7 - cnt)];
		end
	end
endmodule
`default_nettype wire

// ---- verification/test_srpl_preloader.sv ----
// Bench for the preloader: Wishbone tasks, ROM model, resolved wires.
// Assumes srpl_pkg, the ROM model and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module test_srpl_preloader import srpl_pkg::*;;
	logic CLOCK = 0, RST = 1, cyc = 0, stb = 0, we = 0, pull = 0, mute = 0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0000_0000, rd, rdat;
	logic ack, busy, scl_oe, sda_oe, rom_oe, sda_w, act = 0;
	logic present, err;
	int miscompares = 0, cmp_count = 0, cycles = 0;
	localparam logic [31:0] PR = 32'h1 << STAT_PRESENT_BIT;
	localparam logic [31:0] ER = 32'h1 << STAT_ERR_BIT;
	localparam logic [31:0] BZ = 32'h1 << STAT_BUSY_BIT;
	localparam logic [7:0] SC = REG_IMAGE_BASE + 8'h04;
	localparam logic [31:0] M = 32'h0000_007B;
	localparam logic [31:0] OLD = 32'h0000_00A4;
	localparam logic [31:0] EXP = (OLD & ~M) | (32'h0000_005A & M);
	// Records 21h then 25h, each padded to eight bytes, then end of list
	logic [7:0] img [17] = '{8'h21, 8'hAA, 8'hBB, 8'hCC, 8'hDD, 8'h5A,
		8'h5A, 8'h5A, 8'h25, 8'h11, 8'h22, 8'h33, 8'h5A, 8'h5A, 8'h5A,
		8'h5A, 8'hFF};
	assign sda_w = pull & !sda_oe & !rom_oe;
	always #5 CLOCK = ~CLOCK;
	srpl_preloader dut_u (.CLOCK, .RST, .CE(1'b1), .WB_CYC_I(cyc),
		.WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF),
		.WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .SCL_O(),
		.SCL_OE(scl_oe), .SDA_I(sda_w), .SDA_O(), .SDA_OE(sda_oe),
		.ROM_PRESENT_FLAG(present), .LOAD_ERROR_FLAG(err),
		.LOAD_BUSY_FLAG(busy));
	srpl_rom_model rom_u (.clk(CLOCK), .scl(!scl_oe), .sda(sda_w),
		.mute(mute), .oe(rom_oe));
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// A hang in the load shows up here rather than as a silent stall
	always @(posedge CLOCK) begin
		cycles <= cycles + 1;
		act <= RST ? 1'b0 : act | scl_oe | sda_oe;
		if (cycles == 80000) begin
			miscompares++;
			wrap_up();
		end
	end
	task automatic cmp(input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t exp %h got %h", $time, exp, got);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge CLOCK);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge CLOCK); while (ack !== 1'b1);
		r = rdat;
		cyc <= 0;
		stb <= 0;
		we <= 0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		wb(0, a, 32'h0000_0000, rd);
		cmp(exp, rd);
	endtask
	task automatic settle();
		repeat (300) @(posedge CLOCK);
		rdc(REG_STATUS, PR | BZ);
		while (busy !== 1'b0) @(posedge CLOCK);
	endtask
	initial begin
		repeat (4) @(posedge CLOCK);
		RST <= 0;
		repeat (600) @(posedge CLOCK);
		cmp(32'h0000_0000, {31'h0, act});
		cmp(32'h0000_0000, {30'h0, present, err});
		rdc(REG_STATUS, 32'h0000_0000);
		RST <= 1;
		pull <= 1;
		for (int i = 0; i < 17; i++) rom_u.mem[i] = img[i];
		repeat (4) @(posedge CLOCK);
		RST <= 0;
		wb(1, SC, OLD, rd);
		wb(1, REG_STATUS, 32'hFFFF_FFFF, rd);
		rdc(8'h40, 32'h0000_0000);
		settle();
		rdc(REG_STATUS, PR);
		cmp(32'h0000_0002, {30'h0, present, err});
		rdc(SC, EXP);
		rdc(REG_IMAGE_BASE, 32'hAA00_0000);
		cmp(32'h0000_0001, {31'h0, act});
		rom_u.mem[0] = 8'h99;
		wb(1, REG_CONTROL, 32'h1 << CTRL_RELOAD_BIT, rd);
		settle();
		rdc(REG_STATUS, PR | ER);
		cmp(32'h0000_0003, {30'h0, present, err});
		mute <= 1;
		rom_u.mem[0] = 8'h25;
		wb(1, REG_CONTROL, 32'h1 << CTRL_RELOAD_BIT, rd);
		settle();
		rdc(REG_STATUS, PR | ER);
		cmp(32'h0000_0003, {30'h0, present, err});
		rdc(SC, EXP);
		rdc(REG_IMAGE_BASE, 32'hAA00_0000);
		wrap_up();
	end
endmodule
`default_nettype wire
